//--- bmr_biquad.sv
// One second-order filter section, direct form one, combinational
`timescale 1ns/1ns
module bmr_biquad (
    input wire logic signed [bmr_pkg::SW-1:0] x,
    input wire logic signed [bmr_pkg::SW-1:0] x1,
    input wire logic signed [bmr_pkg::SW-1:0] x2,
    input wire logic signed [bmr_pkg::SW-1:0] y1,
    input wire logic signed [bmr_pkg::SW-1:0] y2,
    input wire logic signed [bmr_pkg::CW-1:0] b0,
    input wire logic signed [bmr_pkg::CW-1:0] b1,
    input wire logic signed [bmr_pkg::CW-1:0] b2,
    input wire logic signed [bmr_pkg::CW-1:0] a1,
    input wire logic signed [bmr_pkg::CW-1:0] a2,
    output logic signed [bmr_pkg::SW-1:0] y
);
    import bmr_pkg::*;

    // --------
    // Multiply and accumulate
    // --------
    logic signed [63:0] acc; // Full precision sum

    // Feed forward minus feedback, widened before the product so nothing wraps
    always_comb begin
        acc = 64'(x) * b0 + 64'(x1) * b1 + 64'(x2) * b2
            - 64'(y1) * a1 - 64'(y2) * a2;
        y = bmr_sat(48'(acc >>> COEF_FRAC));
    end

endmodule : bmr_biquad

//--- bmr_checker.sv
// Checker of bus and frame timing at the router ports
`timescale 1ns/1ns
module bmr_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [bmr_pkg::NCH*bmr_pkg::SW-1:0] out_frame
);
    import bmr_pkg::*;
    // --------
    // Properties
    // --------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rd: assert property (p_rd) else $error("read late");
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bh: assert property (p_bh) else $error("write answer dropped");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("read answer dropped");
    property p_tk; in_valid && in_ready |=> !in_ready [*8]; endproperty
    a_tk: assert property (p_tk) else $error("frame overrun");
    property p_lt; in_valid && in_ready |-> ##[40:44] out_valid; endproperty
    a_lt: assert property (p_lt) else $error("frame late");
    property p_pl; out_valid |=> !out_valid; endproperty
    a_pl: assert property (p_pl) else $error("pulse long");
    property p_rr; $rose(out_valid) |-> $rose(in_ready); endproperty
    a_rr: assert property (p_rr) else $error("ready not back");
    property p_fs; !out_valid |-> $stable(out_frame); endproperty
    a_fs: assert property (p_fs) else $error("output moved");
    c_fr: cover property (in_valid && in_ready ##[40:44] out_valid);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : bmr_checker
bind bmr_top bmr_checker i_bmr_checker (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .in_valid, .in_ready, .out_valid, .out_frame);

//--- bmr_pkg.sv
// Shared constants, types and helpers of the bass management router
package bmr_pkg;

    // --------
    // Sizes
    // --------
    localparam int NCH = 8;   // Output channels
    localparam int SW = 24;   // Sample width
    localparam int CW = 32;   // Coefficient width, Q2.30
    localparam int BW = 32;   // Low-frequency bus width
    localparam int NCOEF = 10; // Five low-band then five high-band coefficients

    // --------
    // Register offsets
    // --------
    localparam logic [7:0] A_CTRL = 8'h00;  // Global switch
    localparam logic [7:0] A_FREQ = 8'h04;  // Crossover frequency
    localparam logic [7:0] A_STAT = 8'h08;  // Status, read only
    localparam logic [7:0] A_COEF0 = 8'h10; // b0 b1 b2 a1 a2 low, then high
    localparam logic [7:0] A_COEF9 = 8'h34; // Last coefficient word
    localparam logic [7:0] A_FILT0 = 8'h40; // Per channel enable and pan
    localparam logic [7:0] A_FILT7 = 8'h5c;
    localparam logic [7:0] A_GAIN0 = 8'h60; // Per channel bus return gains
    localparam logic [7:0] A_GAIN7 = 8'h7c;

    // --------
    // Field positions
    // --------
    localparam int CTRL_BM = 0;      // Bass management on
    localparam int FILT_EN = 0;      // Filtering enable
    localparam int FILT_PAN = 8;     // Signed pan, 8 bits
    localparam int GAIN_L = 0;       // Left bus return gain, Q1.7
    localparam int GAIN_R = 8;       // Right bus return gain, Q1.7
    localparam int STAT_BUSY = 0;    // Frame in progress
    localparam int STAT_BYP = 1;     // Crossover bypassed
    localparam int STAT_CNT = 16;    // Frame counter, 16 bits

    // --------
    // Reset values and limits
    // --------
    localparam logic [8:0] FREQ_BYP = 9'h000;  // Bypass code
    localparam logic [8:0] FREQ_MIN = 9'h014;  // 20 Hz
    localparam logic [8:0] FREQ_MAX = 9'h12c;  // 300 Hz
    localparam logic [31:0] RST_CTRL = 32'h0000_0001;
    localparam logic [31:0] RST_FREQ = 32'h0000_0000;
    localparam logic [31:0] RST_FILT = 32'h0000_0001;
    localparam logic [31:0] RST_GAIN = 32'h0000_0000;
    localparam logic [31:0] COEF_ONE = 32'h4000_0000; // Unity in Q2.30
    localparam logic [31:0] COEF_ZERO = 32'h0000_0000;
    localparam int COEF_FRAC = 30;
    localparam logic signed [9:0] PAN_CTR = 10'sh080; // Centre pan weight
    localparam int PAN_SH = 8;
    localparam int GAIN_SH = 7;

    // --------
    // Bus answers and states
    // --------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_FILT, ST_MIX, ST_OUT} bmr_state_type;

    // Clamp a wide value to the sample range
    function automatic logic signed [SW-1:0] bmr_sat(input logic signed [47:0] v);
        if (v > 48'sh7f_ffff) begin
            return 24'sh7f_ffff;
        end else if (v < -48'sh80_0000) begin
            return 24'sh80_0000;
        end
        return SW'(v);
    endfunction : bmr_sat

endpackage : bmr_pkg

//--- bmr_stream_model.sv
// Upstream source and downstream sink model of the audio stream
`timescale 1ns/1ns
module bmr_stream_model (
    input wire logic aclk,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [bmr_pkg::NCH*bmr_pkg::SW-1:0] out_frame,
    output logic in_valid,
    output logic [bmr_pkg::NCH*bmr_pkg::SW-1:0] in_frame,
    output logic signed [bmr_pkg::SW-1:0] lfe_in
);
    import bmr_pkg::*;
    // --------
    // Frame transfer
    // --------
    initial begin
        in_valid = 1'b0;
        in_frame = '0;
        lfe_in = '0;
    end
    // Offer one frame, hold it until taken, then wait for the result
    task automatic send(input logic [NCH*SW-1:0] f, input logic [SW-1:0] l, output logic [NCH*SW-1:0] y);
        @(posedge aclk);
        in_valid <= 1'b1;
        in_frame <= f;
        lfe_in <= l;
        do @(posedge aclk); while (!in_ready);
        in_valid <= 1'b0;
        in_frame <= ~f; // Released lines carry no stale data
        lfe_in <= ~l;
        do @(posedge aclk); while (!out_valid);
        y = out_frame;
    endtask : send
endmodule : bmr_stream_model

//--- bmr_top.sv
// Bass management router: crossover split, bus panning and bus return mix
// Summary of operation
// - Fourth-order split: two identical sections per band
// - One crossover setting shared by all channels
// - Frequency is bypass or 20 to 300 Hz
// - Global switch off stops main-channel bass rerouting
// - Switch off leaves LFE routing untouched
// - LFE summed with split bass into buses
// - Per-channel enable removes low band into buses
// - Enable off still allows bus return mixing
// - Pan splits low band; centre equal, sign selects
// - Pan ignored when channel filtering is off
// - Per-channel gains add both buses into output
// - Reset defaults apply until software overwrites them
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module bmr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [bmr_pkg::NCH*bmr_pkg::SW-1:0] in_frame,
    input wire logic signed [bmr_pkg::SW-1:0] lfe_in,
    output logic out_valid,
    output logic [bmr_pkg::NCH*bmr_pkg::SW-1:0] out_frame
);
    import bmr_pkg::*;

    // Merge written bytes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // --------
    // Register file and shadows
    // --------
    logic [31:0] ctrl, next_ctrl;           // Global switch
    logic [31:0] freq, next_freq;           // Crossover frequency
    logic [31:0] coef [NCOEF];              // Live coefficients
    logic [31:0] next_coef [NCOEF];
    logic [31:0] filt [NCH];                // Enable and pan
    logic [31:0] next_filt [NCH];
    logic [31:0] gain [NCH];                // Bus return gains
    logic [31:0] next_gain [NCH];
    logic [31:0] sh_ctrl, sh_freq;          // Frame copies
    logic [31:0] sh_coef [NCOEF];
    logic [31:0] sh_filt [NCH];
    logic [31:0] sh_gain [NCH];
    logic load_sh;                          // Copy live to shadow

    // --------
    // Bus slave state
    // --------
    logic [7:0] wa, next_wa;                // Held write address
    logic [31:0] wd, next_wd;               // Held write data
    logic [3:0] ws, next_ws;                // Held strobes
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] mw;                        // Merged write word
    logic [7:0] ra;                         // Read address
    logic [15:0] frame_cnt, next_cnt;       // Completed frames

    // --------
    // Datapath state
    // --------
    bmr_state_type state, next_state;
    logic [2:0] ch, next_ch;                // Channel in work
    logic [1:0] sec, next_sec;              // Section in work
    logic signed [SW-1:0] tmp, next_tmp;    // First section output
    logic signed [SW-1:0] lo, next_lo;      // Low band result
    logic signed [BW-1:0] bus_l, next_bus_l;
    logic signed [BW-1:0] bus_r, next_bus_r;
    logic signed [SW-1:0] smp [NCH];        // Frame input
    logic signed [SW-1:0] next_smp [NCH];
    logic signed [SW-1:0] mainv [NCH];      // Path after split
    logic signed [SW-1:0] next_main [NCH];
    logic [NCH*SW-1:0] next_out;
    logic next_ov, next_ir;
    logic signed [SW-1:0] hx1 [NCH*4];      // Filter history
    logic signed [SW-1:0] hx2 [NCH*4];
    logic signed [SW-1:0] hy1 [NCH*4];
    logic signed [SW-1:0] hy2 [NCH*4];
    logic [4:0] si;                         // History index
    logic signed [SW-1:0] bq_x, bq_y;       // Section input and output
    logic [3:0] cb;                         // Coefficient base
    logic split_on;                         // Low band extracted
    logic signed [9:0] pan, gl, gr;         // Pan weights
    logic signed [41:0] mix;                // Bus return sum

    // --------
    // Bus slave and register writes
    // --------

    // Accept address and data in either order, write when both held
    always_comb begin
        next_wa = wa;
        next_wd = wd;
        next_ws = ws;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_ctrl = ctrl;
        next_freq = freq;
        next_coef = coef;
        next_filt = filt;
        next_gain = gain;
        mw = 32'h0;
        ra = s_axi_araddr[7:0];
        if (s_axi_awvalid && s_axi_awready) begin
            next_wa = s_axi_awaddr[7:0];
            next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wd = s_axi_wdata;
            next_ws = s_axi_wstrb;
            next_wready = 1'b0;
        end
        // Both halves held: perform the write
        if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (wa[7:2] == A_CTRL[7:2]) begin
                next_ctrl = merge(ctrl, wd, ws);
            end else if (wa[7:2] == A_FREQ[7:2]) begin
                mw = merge(freq, wd, ws);
                // Only bypass or the legal range is stored
                if (mw[31:9] == 23'h0 && (mw[8:0] == FREQ_BYP
                    || (mw[8:0] >= FREQ_MIN && mw[8:0] <= FREQ_MAX))) begin
                    next_freq = mw;
                end else begin
                    next_bresp = RESP_SLVERR;
                end
            end else if (wa[7:2] == A_STAT[7:2]) begin
                next_bresp = RESP_OKAY; // Read only, write ignored
            end else if (wa >= A_COEF0 && wa <= A_COEF9 + 8'h3) begin
                next_coef[4'(wa[7:2] - A_COEF0[7:2])] = merge(coef[4'(wa[7:2] - A_COEF0[7:2])], wd, ws);
            end else if (wa >= A_FILT0 && wa <= A_FILT7 + 8'h3) begin
                next_filt[wa[4:2]] = merge(filt[wa[4:2]], wd, ws);
            end else if (wa >= A_GAIN0 && wa <= A_GAIN7 + 8'h3) begin
                next_gain[wa[4:2]] = merge(gain[wa[4:2]], wd, ws);
            end else begin
                next_bresp = RESP_SLVERR; // Unmapped
            end
        end
        // Response taken: reopen both channels
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        // Read: answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            if (ra[7:2] == A_CTRL[7:2]) begin
                next_rdata = ctrl;
            end else if (ra[7:2] == A_FREQ[7:2]) begin
                next_rdata = freq;
            end else if (ra[7:2] == A_STAT[7:2]) begin
                next_rdata[STAT_BUSY] = (state != ST_IDLE);
                next_rdata[STAT_BYP] = (freq[8:0] == FREQ_BYP);
                next_rdata[STAT_CNT +: 16] = frame_cnt;
            end else if (ra >= A_COEF0 && ra <= A_COEF9 + 8'h3) begin
                next_rdata = coef[4'(ra[7:2] - A_COEF0[7:2])];
            end else if (ra >= A_FILT0 && ra <= A_FILT7 + 8'h3) begin
                next_rdata = filt[ra[4:2]];
            end else if (ra >= A_GAIN0 && ra <= A_GAIN7 + 8'h3) begin
                next_rdata = gain[ra[4:2]];
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Register the bus and configuration group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa <= 8'h0;
            wd <= 32'h0;
            ws <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
            ctrl <= RST_CTRL;
            freq <= RST_FREQ;
            for (int k = 0; k < NCOEF; k++) begin
                coef[k] <= (k == 0 || k == 5) ? COEF_ONE : COEF_ZERO;
            end
            for (int i = 0; i < NCH; i++) begin
                filt[i] <= RST_FILT;
                gain[i] <= RST_GAIN;
            end
        end else begin
            wa <= next_wa;
            wd <= next_wd;
            ws <= next_ws;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            ctrl <= next_ctrl;
            freq <= next_freq;
            coef <= next_coef;
            filt <= next_filt;
            gain <= next_gain;
        end
    end

    // Shadows change only when a frame is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_ctrl <= RST_CTRL;
            sh_freq <= RST_FREQ;
            for (int k = 0; k < NCOEF; k++) begin
                sh_coef[k] <= COEF_ZERO;
            end
            for (int i = 0; i < NCH; i++) begin
                sh_filt[i] <= RST_FILT;
                sh_gain[i] <= RST_GAIN;
            end
        end else if (load_sh) begin
            sh_ctrl <= ctrl;
            sh_freq <= freq;
            sh_coef <= coef;
            sh_filt <= filt;
            sh_gain <= gain;
        end
    end

    // --------
    // Crossover section
    // --------
    assign si = {ch, sec};
    assign cb = sec[1] ? 4'h5 : 4'h0; // Low band first, then high
    assign bq_x = sec[0] ? tmp : smp[ch];

    bmr_biquad u_bq (
        .x(bq_x),
        .x1(hx1[si]),
        .x2(hx2[si]),
        .y1(hy1[si]),
        .y2(hy2[si]),
        .b0(sh_coef[cb]),
        .b1(sh_coef[cb + 4'h1]),
        .b2(sh_coef[cb + 4'h2]),
        .a1(sh_coef[cb + 4'h3]),
        .a2(sh_coef[cb + 4'h4]),
        .y(bq_y)
    );

    // --------
    // Frame sequencer
    // --------

    // Walk channels through four sections, then mix the buses back
    always_comb begin
        next_state = state;
        next_ch = ch;
        next_sec = sec;
        next_tmp = tmp;
        next_lo = lo;
        next_bus_l = bus_l;
        next_bus_r = bus_r;
        next_smp = smp;
        next_main = mainv;
        next_out = out_frame;
        next_ov = 1'b0;
        next_ir = in_ready;
        next_cnt = frame_cnt;
        load_sh = 1'b0;
        // Split active only with switch, channel enable and no bypass
        split_on = sh_ctrl[CTRL_BM] && sh_filt[ch][FILT_EN] && sh_freq[8:0] != FREQ_BYP;
        pan = 10'(signed'(sh_filt[ch][FILT_PAN +: 8]));
        gl = PAN_CTR - pan;
        gr = PAN_CTR + pan;
        mix = 42'(bus_l) * signed'({1'b0, sh_gain[ch][GAIN_L +: 8]})
            + 42'(bus_r) * signed'({1'b0, sh_gain[ch][GAIN_R +: 8]});
        case (state)
            ST_IDLE: begin
                // Take one frame and freeze the settings
                if (in_valid && in_ready) begin
                    for (int i = 0; i < NCH; i++) begin
                        next_smp[i] = in_frame[i*SW +: SW];
                    end
                    next_bus_l = BW'(lfe_in);
                    next_bus_r = BW'(lfe_in);
                    next_ir = 1'b0;
                    load_sh = 1'b1;
                    next_ch = 3'h0;
                    next_sec = 2'h0;
                    next_state = ST_FILT;
                end
            end
            ST_FILT: begin
                case (sec)
                    2'h0: next_tmp = bq_y;
                    2'h1: next_lo = bq_y;
                    2'h2: next_tmp = bq_y;
                    default: begin
                        // High band stays, low band goes to the buses
                        if (split_on) begin
                            next_main[ch] = bq_y;
                            next_bus_l = bus_l + BW'((34'(lo) * gl) >>> PAN_SH);
                            next_bus_r = bus_r + BW'((34'(lo) * gr) >>> PAN_SH);
                        end else begin
                            next_main[ch] = smp[ch];
                        end
                    end
                endcase
                next_sec = sec + 2'h1;
                if (sec == 2'h3) begin
                    next_ch = ch + 3'h1;
                    if (ch == 3'(NCH - 1)) begin
                        next_state = ST_MIX;
                    end
                end
            end
            ST_MIX: begin
                // Return both buses into every output, clamped
                next_main[ch] = bmr_sat(48'(mainv[ch]) + 48'(mix >>> GAIN_SH));
                next_ch = ch + 3'h1;
                if (ch == 3'(NCH - 1)) begin
                    next_state = ST_OUT;
                end
            end
            ST_OUT: begin
                // Present the whole frame at once and reopen the input
                for (int i = 0; i < NCH; i++) begin
                    next_out[i*SW +: SW] = mainv[i];
                end
                next_ov = 1'b1;
                next_ir = 1'b1;
                next_cnt = frame_cnt + 16'h1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Register the datapath group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            ch <= 3'h0;
            sec <= 2'h0;
            tmp <= '0;
            lo <= '0;
            bus_l <= '0;
            bus_r <= '0;
            out_frame <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b1;
            frame_cnt <= 16'h0;
            for (int i = 0; i < NCH; i++) begin
                smp[i] <= '0;
                mainv[i] <= '0;
            end
        end else begin
            state <= next_state;
            ch <= next_ch;
            sec <= next_sec;
            tmp <= next_tmp;
            lo <= next_lo;
            bus_l <= next_bus_l;
            bus_r <= next_bus_r;
            out_frame <= next_out;
            out_valid <= next_ov;
            in_ready <= next_ir;
            frame_cnt <= next_cnt;
            smp <= next_smp;
            mainv <= next_main;
        end
    end

    // Filter history, one slot per channel and section
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int j = 0; j < NCH*4; j++) begin
                hx1[j] <= '0;
                hx2[j] <= '0;
                hy1[j] <= '0;
                hy2[j] <= '0;
            end
        end else if (state == ST_FILT) begin
            hx1[si] <= bq_x;
            hx2[si] <= hx1[si];
            hy1[si] <= bq_y;
            hy2[si] <= hy1[si];
        end
    end

endmodule : bmr_top

//--- bmr_top_test.sv
// Self-checking bench of the bass management router
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module bmr_top_test;
    import bmr_pkg::*;
    // --------
    // Signals and instances
    // --------
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic in_valid, in_ready, out_valid;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [NCH*SW-1:0] in_frame, out_frame, y;
    logic signed [SW-1:0] lfe_in;
    int failures = 0, total_checks = 0;
    logic [31:0] fq [4] = '{32'd19, 32'd20, 32'd300, 32'd301};
    logic [1:0] fr [4] = '{RESP_SLVERR, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
    logic [7:0] pn [3] = '{8'h80, 8'h7f, 8'h00};
    logic [SW-1:0] el [3] = '{24'h110, 24'h11, 24'h90};
    logic [SW-1:0] er [3] = '{24'h10, 24'h10f, 24'h90};
    always #5 aclk = ~aclk;
    bmr_top i_bmr_top (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .in_valid,
        .in_ready, .in_frame, .lfe_in, .out_valid, .out_frame);
    bmr_stream_model i_bmr_stream_model (.aclk, .in_ready, .out_valid, .out_frame, .in_valid, .in_frame, .lfe_in);
    // --------
    // Bus and frame tasks
    // --------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= {24'h0, a};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // Channel 0 carries the test sample, the others stay silent
    task automatic frame(input logic [SW-1:0] x, input logic [SW-1:0] l);
        logic [NCH*SW-1:0] f;
        f = '0;
        f[SW-1:0] = x;
        i_bmr_stream_model.send(f, l, y);
    endtask : frame
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // --------
    // Tests
    // --------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CTRL);
        `CHK(d, RST_CTRL)
        rd(A_FILT0 + 8'h1c);
        `CHK(d, RST_FILT)
        rd(8'hf0);
        `CHK(r, RESP_SLVERR)
        $display("test reset done");
        wr(A_GAIN0, 32'h80);
        frame(24'h100, 24'h10);
        `CHK(y[SW-1:0], 24'h110)
        `CHK(y[SW+:SW], 24'h0)
        for (int i = 0; i < 4; i++) begin
            wr(A_FREQ, fq[i]);
            `CHK(r, fr[i])
        end
        rd(A_FREQ);
        `CHK(d, 32'h12c)
        $display("test bypass and range done");
        wr(A_GAIN0 + 8'h04, 32'h80);
        wr(A_GAIN0 + 8'h08, 32'h8000);
        for (int i = 0; i < 3; i++) begin
            wr(A_FILT0, {16'h0, pn[i], 8'h01});
            frame(24'h100, 24'h10);
            `CHK(y[SW-1:0], el[i] + 24'h100)
            `CHK(y[SW+:SW], el[i])
            `CHK(y[2*SW+:SW], er[i])
        end
        fork
            frame(24'h100, 24'h10);
            begin repeat (6) @(posedge aclk); wr(A_CTRL, 32'h0); end
        join
        `CHK(y[SW+:SW], 24'h90)
        frame(24'h100, 24'h10);
        `CHK(y[SW+:SW], 24'h10)
        `CHK(y[SW-1:0], 24'h110)
        $display("test pan and switch done");
        wr(A_CTRL, 32'h1);
        wr(A_FILT0, 32'h8000);
        frame(24'h100, 24'h10);
        `CHK(y[SW+:SW], 24'h10)
        `CHK(y[SW-1:0], 24'h110)
        frame(24'h7fffff, 24'h100);
        `CHK(y[SW-1:0], 24'h7fffff)
        frame(24'h800000, 24'hffff00);
        `CHK(y[SW-1:0], 24'h800000)
        $display("test enable and saturation done");
        tally_and_finish();
    end
    // Cut a hang short
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        tally_and_finish();
    end
endmodule : bmr_top_test
